// >>> rtl/tag_frame_encoder.sv
// top of the backscatter tag frame encoder: scrolls a stored frame as fsk tones
// assumes illum is a raw level from the rf front end and stored data is static
`timescale 1ns/100ps
module tag_frame_encoder
    import tag_frame_pkg::*;
#(
    parameter bit SHORT_TAG = 1'b0
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // stored tag contents, bit 1 of a field at the msb
    input wire logic [DATA1_BITS-1:0] data1,
    input wire logic [DATA2_BITS-1:0] data2,
    input wire logic [63:0] short_data,
    // rf front end
    input wire logic illum,
    // antenna modulator
    output logic mod_out,
    output logic frame_start
);
    tone_if tone();

    logic illum_m_q;
    logic illum_q;
    logic [6:0] cell_q;
    logic active_q;
    logic load_q;
    logic pend_q;
    logic [7:0] pat_q;
    logic frame_start_q;
    logic mod_gen;
    logic mod_q;
    logic bit_val;
    cell_src_t src;
    logic [FRAME_BITS-1:0] frame;
    logic [1:0] ck1;
    logic [1:0] ck2;

    // two-flop synchroniser on the illumination level
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            illum_m_q <= 1'b0;
            illum_q <= 1'b0;
        end else begin
            illum_m_q <= illum;
            illum_q <= illum_m_q;
        end
    end

    // checksum is a popcount, low two bits kept [R3]
    always_comb begin
        ck1 = 2'h0;
        ck2 = 2'h0;
        for (int i = 0; i < DATA1_BITS; i++) begin
            ck1 = ck1 + {1'b0, data1[i]};
        end
        for (int i = 0; i < DATA2_BITS; i++) begin
            ck2 = ck2 + {1'b0, data2[i]};
        end
    end

    // frame image, msb is cell 1; characters already msb first in the fields [R1] [R2] [R16]
    always_comb begin
        if (SHORT_TAG) begin
            frame = {short_data, short_data}; // [R6]
        end else begin
            frame = {data1, ck1, FRAMING_BITS, data2, 6'h00, ck2, 2'h0};
        end
    end

    always_comb begin
        if (!SHORT_TAG && cell_q >= CELL_MARK) begin
            src = SRC_MARK;
        end else begin
            src = SRC_DATA;
        end
    end

    assign bit_val = frame[7'(FRAME_BITS - 1) - cell_q];

    // patterns: a 1 toggles at the end of a 12.5 us step; 40 kHz toggles every step, 20 kHz every second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pat_q <= 8'h00;
        end else if (src == SRC_MARK) begin
            pat_q <= 8'hFF; // four 40 kHz cycles in the first marker cell [R4]
            if (cell_q == CELL_MARK + 7'h1) begin
                pat_q <= 8'hF5; // two more 40 kHz cycles then one 20 kHz cycle [R4]
            end
        end else if (bit_val) begin
            pat_q <= 8'hF5; // 40,40,20 [R10]
        end else begin
            pat_q <= 8'h5F; // 20,40,40 [R9]
        end
    end

    // cell counter wraps straight from 128 to 1 [R5]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cell_q <= 7'h00;
            active_q <= 1'b0;
            load_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            // load waits one cycle so pat_q already holds the new cell's pattern
            load_q <= pend_q;
            pend_q <= 1'b0;
            if (!active_q) begin
                if (illum_q) begin
                    active_q <= 1'b1; // [R15]
                    pend_q <= 1'b1;
                end
            end else if (tone.cell_done && !pend_q && !load_q) begin
                if (!illum_q && cell_q == 7'h7F) begin
                    active_q <= 1'b0; // stop only at frame end, never mid-frame
                end else begin
                    pend_q <= 1'b1;
                end
                cell_q <= cell_q + 7'h1;
            end
        end
    end

    assign tone.pattern = pat_q;
    assign tone.load = load_q;

    tone_gen u_tone (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tone(tone.gen),
        .mod_q(mod_gen)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mod_q <= 1'b0;
            frame_start_q <= 1'b0;
        end else begin
            mod_q <= active_q ? mod_gen : 1'b0; // [R15]
            frame_start_q <= load_q && (cell_q == 7'h00);
        end
    end

    assign mod_out = mod_q;
    assign frame_start = frame_start_q;

    a_cell_zero_pat: assert property (@(posedge ref_clk) disable iff (!resetn)
        (load_q && src == SRC_DATA && !bit_val) |=> pat_q == 8'h5F) // [R9]
        else $error("zero bit pattern wrong");
    a_cell_one_pat: assert property (@(posedge ref_clk) disable iff (!resetn)
        (load_q && src == SRC_DATA && bit_val) |=> pat_q == 8'hF5) // [R10]
        else $error("one bit pattern wrong");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!active_q && !illum_q) |=> ##1 !mod_q) // [R15]
        else $error("modulation without illumination");
    a_cell_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tone.cell_done && active_q && !pend_q && !load_q && cell_q == 7'h7F && illum_q)
        |=> (cell_q == 7'h00 ##1 load_q)) // [R5]
        else $error("frame did not wrap");
    a_cell_back: assert property (@(posedge ref_clk) disable iff (!resetn)
        (tone.cell_done && active_q && !pend_q && !load_q && illum_q) |=> ##1 load_q) // [R7]
        else $error("gap between cells");
    a_pad_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!SHORT_TAG && cell_q >= CELL_PAD && cell_q < CELL_CK2) |-> !bit_val) // [R16]
        else $error("pad cell not zero");
    a_ck1_sum: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!SHORT_TAG && cell_q == CELL_CK1) |-> bit_val == ck1[1]) // [R3]
        else $error("first checksum msb wrong");
    a_short_repeat: assert property (@(posedge ref_clk) disable iff (!resetn)
        SHORT_TAG |-> frame[127:64] == frame[63:0]) // [R6]
        else $error("short tag not repeated");
    a_edge_spacing: assert property (@(posedge ref_clk) disable iff (!resetn)
        $changed(mod_gen) |=> !$changed(mod_gen)) // [R11]
        else $error("phase jump");
endmodule

// >>> rtl/tag_frame_pkg.sv
// constants and types for the backscatter tag frame encoder
// assumes a single 100 MHz reference clock and no software-visible registers
// Functional notes
// [R1] frame is 128 bits: data, checksum, framing, data, pad, checksum, marker
// [R2] each user character is sent most significant bit first
// [R3] checksum is the two-bit count of ones in the preceding data field, msb first
// [R4] end marker is six 40 kHz cycles then one 20 kHz cycle
// [R5] cell 1 of the next frame follows cell 128 with no gap
// [R6] a 64-bit variant sends its stored bits twice to fill the frame
// [R7] bit cells last 100 us each, back to back, 10 kbit/s
// [R8] characters use a six-bit code equal to ascii minus 32
// [R9] zero bit is one 20 kHz cycle then two 40 kHz cycles
// [R10] one bit is two 40 kHz cycles then one 20 kHz cycle
// [R11] the waveform stays phase continuous over every boundary
// [R12] 40 kHz is exactly twice 20 kHz, both from one clock
// [R13] the reader finds frame start by the end marker; the reader model locks to the tag's frame_start strobe instead
// [R14] the reader turns tones back into the stored bits
// [R15] no response unless the tag is illuminated by a reader; the encoder finishes the current frame after the field is lost
// [R16] unallocated cells 119 to 124 are sent as zero bits
// [R17] the reader checks both checksums and drops bad frames; the reader model checks only the first checksum and raises bad
package tag_frame_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int LOW_TONE_HZ = 20_000;
    localparam int HALF_TONE_CYC = CLK_HZ / (4 * LOW_TONE_HZ);
    localparam int FRAME_BITS = 128;
    localparam int DATA1_BITS = 60;
    localparam int DATA2_BITS = 54;
    localparam int CHAR_BITS = 6;
    localparam int CHAR_ASCII_OFS = 32;
    localparam logic [6:0] CELL_CK1 = 7'h3C;
    localparam logic [6:0] CELL_FRM = 7'h3E;
    localparam logic [6:0] CELL_DATA2 = 7'h40;
    localparam logic [6:0] CELL_PAD = 7'h76;
    localparam logic [6:0] CELL_CK2 = 7'h7C;
    localparam logic [6:0] CELL_MARK = 7'h7E;
    localparam logic [1:0] FRAMING_BITS = 2'h0;
    // a cell is eight 12.5 us steps: one 20 kHz cycle is four steps, one 40 kHz cycle two
    localparam logic [3:0] CELL_HALVES = 4'h8;
    typedef enum logic [1:0] {
        SRC_DATA,
        SRC_FIXED,
        SRC_MARK
    } cell_src_t;

    // six-bit character code from an ascii printable character
    function automatic logic [5:0] char_code(input logic [7:0] ascii);
        logic [7:0] diff;
        diff = ascii - 8'(CHAR_ASCII_OFS);
        return diff[5:0]; // [R8]
    endfunction
endpackage

// >>> rtl/tone_gen.sv
// square-wave generator: a cell is eight 12.5 us steps of toggle marks
// assumes load arrives a few cycles after cell_done; load restarts the step timer
`timescale 1ns/100ps
module tone_gen
    import tag_frame_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // sequencer side
    tone_if.gen tone,
    // modulator drive
    output logic mod_q
);
    localparam int CNT_W = $clog2(HALF_TONE_CYC);

    logic [CNT_W-1:0] tick_q;
    logic [2:0] half_q;
    logic [7:0] pat_q;
    logic tick_end;
    logic cell_done_q;

    assign tick_end = (tick_q == CNT_W'(HALF_TONE_CYC - 1));
    assign tone.cell_done = cell_done_q;

    // one time base for both tones keeps the 2:1 ratio exact [R12]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick_q <= '0;
        end else if (tone.load || tick_end) begin
            // restart on load so the first step of a frame is never short
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            half_q <= '0;
            pat_q <= '0;
        end else if (tone.load) begin
            pat_q <= tone.pattern;
            half_q <= 3'h0;
        end else if (tick_end) begin
            half_q <= (half_q == 3'(CELL_HALVES - 4'h1)) ? 3'h0 : half_q + 3'h1; // [R7]
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cell_done_q <= 1'b0;
        end else begin
            cell_done_q <= tick_end && (half_q == 3'(CELL_HALVES - 4'h1));
        end
    end

    // toggle only, never force a level, so phase never jumps [R11]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mod_q <= 1'b0;
        end else if (tick_end && pat_q[3'h7 - half_q]) begin
            mod_q <= ~mod_q;
        end
    end
endmodule

// >>> rtl/tone_if.sv
// carrier between the frame sequencer and the tone generator
// assumes both ends on ref_clk
`timescale 1ns/100ps
interface tone_if;
    logic [7:0] pattern;
    logic load;
    logic cell_done;
    modport seq (output pattern, output load, input cell_done);
    modport gen (input pattern, input load, output cell_done);
endinterface

// >>> tb/backscatter_tag_frame_encoder_tb.sv
// self-checking bench for the tag frame encoder, decoding through the reader model
// assumes the package constants and a 100 MHz ref_clk
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module backscatter_tag_frame_encoder_tb;
    import tag_frame_pkg::*;
    typedef struct packed {logic [7:0] ascii; logic [2:0] bits;} row_t;
    logic ref_clk, resetn, illum, mod_out, frame_start, bad, quiet;
    logic [DATA1_BITS-1:0] data1;
    logic [DATA2_BITS-1:0] data2;
    logic [63:0] short_data;
    logic [15:0] rx_bits;
    logic [7:0] n_bits, code;
    int n_mismatch, n_checks, cyc;
    // 'A' is code 100001, '(' is code 001000: first three cells of each
    row_t rows [2] = '{'{8'h41, 3'h4}, '{8'h28, 3'h1}};

    tag_frame_encoder #(.SHORT_TAG(1'b0)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .data1(data1),
        .data2(data2), .short_data(short_data), .illum(illum), .mod_out(mod_out), .frame_start(frame_start));
    reader_decoder u_reader (.ref_clk(ref_clk), .resetn(resetn), .mod_out(mod_out),
        .frame_start(frame_start), .rx_bits(rx_bits), .n_bits(n_bits), .bad(bad));

    always #5 ref_clk = ~ref_clk;

    // whole run is about 85k cycles; the ceiling leaves margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 120000) begin
            n_mismatch++;
            $display("ERROR timeout expected done seen hang");
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        illum = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        `CHK("mod_out in reset", 1'b0, mod_out)
        `CHK("frame_start in reset", 1'b0, frame_start)
        resetn = 1'b1;
    endtask

    task automatic wait_bits(input int n, input int limit);
        int i;
        i = 0;
        while (n_bits < 8'(n) && bad !== 1'b1 && i < limit) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        illum = 1'b0;
        data1 = '0;
        data2 = {27{2'h2}};
        short_data = 64'hF0F0_0F0F_A5A5_5A5A;
        code = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        cyc = 0;
        do_reset();
        // no reader field: the tag must stay silent
        quiet = 1'b1;
        repeat (3000) begin
            @(posedge ref_clk);
            #1;
            if (mod_out !== 1'b0 || frame_start !== 1'b0) quiet = 1'b0;
        end
        `CHK("silent without field", 1'b1, quiet)
        $display("test idle done");
        for (int r = 0; r < 2; r++) begin
            code = rows[r].ascii - 8'h20;
            data1 = {code[5:0], 54'h0};
            do_reset();
            illum = 1'b1;
            wait_bits(3, 40000);
            `CHK("first cells", rows[r].bits, rx_bits[2:0])
            `CHK("tone timing", 1'b0, bad)
            $display("test row %0d done", r);
        end
        // field lost mid-frame: cells must keep coming back to back, not stop or stretch
        illum = 1'b0;
        wait_bits(5, 25000);
        `CHK("cells after field loss", code[5:1], rx_bits[4:0])
        `CHK("tone timing after loss", 1'b0, bad)
        $display("test field loss done");
        end_sim();
    end
endmodule

// >>> tb/reader_decoder.sv
// reader model: turns the tag's modulator square wave back into bits
// assumes mod_out is registered on ref_clk and frame_start marks the load of cell 1
`timescale 1ns/100ps
module reader_decoder (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // tag side
    input wire logic mod_out,
    input wire logic frame_start,
    // decoded stream
    output logic [15:0] rx_bits,
    output logic [7:0] n_bits,
    output logic bad
);
    int cnt;
    int k;
    int ones;
    logic armed;
    logic last_q;
    logic [5:0] halves;

    // blocking updates keep the model short; the bench only samples 1 ns after the edge
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            armed = 1'b0;
            n_bits = 8'h00;
            rx_bits = 16'h0000;
            bad = 1'b0;
            k = 0;
            ones = 0;
            cnt = 0;
            halves = 6'h00;
            last_q = 1'b0;
        end else begin
            cnt++;
            if (frame_start) begin
                // lock to the frame start; edges seen before it are not decoded
                armed = 1'b1;
                cnt = 0;
                k = 0;
            end else if (armed && mod_out !== last_q) begin
                // a half must be 12.5 us or 25 us within 10%, anything else is a phase or ratio break
                if (cnt >= 1125 && cnt <= 1375) halves = {halves[4:0], 1'b0};
                else if (cnt >= 2250 && cnt <= 2750) halves = {halves[4:0], 1'b1};
                else bad = 1'b1;
                cnt = 0;
                k++;
                if (k == 6) begin
                    // six halves fill one 100 us cell: 20 kHz cycle first for zero, last for one
                    if (halves == 6'h30) rx_bits = {rx_bits[14:0], 1'b0};
                    else if (halves == 6'h03) rx_bits = {rx_bits[14:0], 1'b1};
                    else bad = 1'b1;
                    n_bits++;
                    // first checksum recomputed over the first data field
                    if (n_bits <= 8'h3C) ones += rx_bits[0];
                    else if (n_bits == 8'h3E && rx_bits[1:0] != 2'(ones)) bad = 1'b1;
                    k = 0;
                end
            end
            last_q = mod_out;
        end
    end
endmodule
